/* File: common/lsd_map.svh */
// constants for the segment lcd driver core: timing, commands, resets
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH
// system clock and nominal internal oscillator rate
`define LSD_SYS_CLK_HZ 100000000
`define LSD_OSC_HZ 32768
// system clocks per oscillator tick, rounded to nearest
`define LSD_OSC_DIV ((`LSD_SYS_CLK_HZ + `LSD_OSC_HZ / 2) / `LSD_OSC_HZ)
// frame rates and multiplex depth
`define LSD_FRAME_SLOW_HZ 80
`define LSD_FRAME_FAST_HZ 160
`define LSD_PHASES 4
// oscillator ticks per backplane phase, rounded down
`define LSD_PHASE_SLOW (`LSD_OSC_HZ / (`LSD_FRAME_SLOW_HZ * `LSD_PHASES))
`define LSD_PHASE_FAST (`LSD_OSC_HZ / (`LSD_FRAME_FAST_HZ * `LSD_PHASES))
// blink counter bits that mark the off half (ratios 16384/32768/65536)
`define LSD_BLINK_BIT_2HZ 13
`define LSD_BLINK_BIT_1HZ 14
`define LSD_BLINK_BIT_HALF 15
// panel geometry
`define LSD_NUM_ELEC 44
`define LSD_NUM_BP 4
`define LSD_RAM_WORDS 22
`define LSD_PTR_LAST 5'h15
// command byte masks and match values
`define LSD_CMD_MODE_MASK 8'he2
`define LSD_CMD_MODE_VAL 8'h80
`define LSD_CMD_BLINK_MASK 8'hfc
`define LSD_CMD_BLINK_VAL 8'hc0
`define LSD_CMD_PTR_MASK 8'he0
`define LSD_CMD_PTR_VAL 8'h00
`define LSD_CMD_LVL_MASK 8'hc0
`define LSD_CMD_LVL_VAL 8'h40
// mode-set field positions
`define LSD_MODE_F 4
`define LSD_MODE_S 3
`define LSD_MODE_E 2
`define LSD_MODE_BIAS 0
// level-command field positions
`define LSD_LVL_DE 5
`define LSD_LVL_VE 4
// reset values
`define LSD_RST_LEVEL_CODE 4'h0
`define LSD_RST_BLINK 2'h0
`define LSD_RST_PTR 5'h00
`endif

/* File: common/lsd_pkg.sv */
// types shared by the segment lcd driver core
package lsd_pkg;
    // electrode level: vss, lower tap, upper tap, supply
    // with half bias both inner taps stand for the midpoint; low is used
    typedef enum logic [1:0] {
        LSD_LVL_VSS,
        LSD_LVL_LOW,
        LSD_LVL_HIGH,
        LSD_LVL_VDD
    } lsd_level_e;
    // byte stream state after the slave address
    typedef enum logic [1:0] {
        LSD_WR_IDLE,
        LSD_WR_DATA,
        LSD_WR_SKIP
    } lsd_wr_state_e;
    // configuration held by the core
    typedef struct packed {
        logic frame_fast;
        logic osc_en;
        logic disp_en;
        logic bias_select;
        logic [1:0] blink_rate_code;
        logic [3:0] drive_level_code;
        logic level_adjust_en;
        logic supply_detect_en;
    } lsd_cfg_s;
    // timing strobes from the time base
    typedef struct packed {
        logic [1:0] phase;
        logic invert;
        logic frame_start;
        logic blink_off;
    } lsd_tick_s;
endpackage

/* File: core/lsd_core.sv */
// segment lcd driver core: command decode, display ram, panel drive
`timescale 1ns/10ps
`include "lsd_map.svh"
// Functional notes
// - reset drives all backplanes and electrodes high
// - reset selects four-way multiplex, one-third bias
// - reset stops oscillator, bias generator, display
// - reset enables level adjust, disables detect switch
// - reset selects 80 Hz frame, blink off
// - 44x4 display memory, one means segment on
// - memory column n drives backplane n
// - low nibble electrode 2n, high nibble 2n+1
// - display bytes travel most significant bit first
// - all timing from internal oscillator, starts stopped
// - half bias bypasses centre divider element
// - electrodes from phase and latched memory bits
// - four backplanes follow mode and phase
// - pointer command starts single or sequential loading
// - whole-display blink, dividers 16384, 32768, 65536
// - frame rate 80 or 160 Hz by mode bit
// - four-bit drive level, zero is full supply
// - mode-set byte layout; oscillator off forces display off
// - blink byte layout with two-bit rate code
// - pointer byte layout, wraps after 15h to 00h
// - pointer steps only after each data acknowledge
module lsd_core (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic wr_valid_in,
    input wire logic wr_first_in,
    input wire logic [7:0] wr_byte_in,
    input wire logic rd_ack_in,
    output logic [7:0] rd_byte_out,
    output logic [4:0] pointer_out,
    output lsd_pkg::lsd_cfg_s cfg_out,
    output logic bias_gen_on_out,
    output logic divider_center_bypass_out,
    output lsd_pkg::lsd_level_e [43:0] panel_electrode_drive_out,
    output lsd_pkg::lsd_level_e [3:0] backplane_drive_out
);
    // turn a level round for the inverted frame
    function automatic lsd_pkg::lsd_level_e flip_level(
        input lsd_pkg::lsd_level_e lvl,
        input logic inv
    );
        flip_level = inv ? lsd_pkg::lsd_level_e'(2'h3 - 2'(lvl)) : lvl;
    endfunction

    // electrode level for one segment in the current frame
    function automatic lsd_pkg::lsd_level_e seg_level(
        input logic seg_on,
        input logic inv,
        input logic half
    );
        lsd_pkg::lsd_level_e base;
        base = lsd_pkg::LSD_LVL_HIGH;
        if (seg_on) begin
            base = lsd_pkg::LSD_LVL_VSS;
        end else if (half) begin
            base = lsd_pkg::LSD_LVL_VDD;
        end
        seg_level = flip_level(base, inv);
    endfunction

    // backplane level for a selected or idle common
    function automatic lsd_pkg::lsd_level_e bp_level(
        input logic sel,
        input logic inv,
        input logic half
    );
        if (sel) begin
            bp_level = flip_level(lsd_pkg::LSD_LVL_VDD, inv);
        end else if (half) begin
            // midpoint in both polarities
            bp_level = lsd_pkg::LSD_LVL_LOW;
        end else begin
            bp_level = flip_level(lsd_pkg::LSD_LVL_LOW, inv);
        end
    endfunction

    // configuration and stream state
    lsd_pkg::lsd_cfg_s cfg_reg;
    lsd_pkg::lsd_cfg_s cfg_next;
    lsd_pkg::lsd_wr_state_e wr_state_reg;
    lsd_pkg::lsd_wr_state_e wr_state_next;
    logic [4:0] ptr_reg;
    logic [4:0] ptr_next;
    // display ram and the copy shown on the panel
    logic [7:0] ram_reg [`LSD_RAM_WORDS];
    logic [7:0] latch_reg [`LSD_RAM_WORDS];
    logic [7:0] rd_byte_reg;
    lsd_pkg::lsd_level_e [43:0] elec_reg;
    lsd_pkg::lsd_level_e [43:0] elec_next;
    lsd_pkg::lsd_level_e [3:0] bp_reg;
    lsd_pkg::lsd_level_e [3:0] bp_next;
    // strobes from the time base, all in this one clock domain
    lsd_pkg::lsd_tick_s tick;

    // byte classification
    wire is_mode = (wr_byte_in & `LSD_CMD_MODE_MASK) == `LSD_CMD_MODE_VAL;
    wire is_blink = (wr_byte_in & `LSD_CMD_BLINK_MASK) == `LSD_CMD_BLINK_VAL;
    wire is_lvl = (wr_byte_in & `LSD_CMD_LVL_MASK) == `LSD_CMD_LVL_VAL;
    // addresses past the last word are an undefined command and ignored
    wire is_ptr = ((wr_byte_in & `LSD_CMD_PTR_MASK) == `LSD_CMD_PTR_VAL)
        && (wr_byte_in[4:0] <= `LSD_PTR_LAST);
    // a byte right after the slave address is always a command
    wire cmd_take = wr_valid_in && wr_first_in;
    // data bytes count only after a valid pointer command
    wire data_take = wr_valid_in && !wr_first_in
        && (wr_state_reg == lsd_pkg::LSD_WR_DATA);
    // the pointer moves once per acknowledged data byte
    wire ptr_step = data_take || rd_ack_in;
    wire [4:0] ptr_inc = (ptr_reg == `LSD_PTR_LAST) ? 5'h00
        : ptr_reg + 5'h01;
    // display shows only with oscillator and display both on
    wire disp_live = cfg_reg.osc_en && cfg_reg.disp_en;

    // command decode; unknown bytes change nothing but the stream state
    always_comb begin
        cfg_next = cfg_reg;
        ptr_next = ptr_step ? ptr_inc : ptr_reg;
        wr_state_next = wr_state_reg;
        if (cmd_take) begin
            // a command other than a pointer command as first byte makes later bytes ignored
            wr_state_next = lsd_pkg::LSD_WR_SKIP;
            if (is_ptr) begin
                ptr_next = wr_byte_in[4:0];
                wr_state_next = lsd_pkg::LSD_WR_DATA;
            end else if (is_mode) begin
                cfg_next.frame_fast = wr_byte_in[`LSD_MODE_F];
                cfg_next.osc_en = wr_byte_in[`LSD_MODE_S];
                // oscillator off always turns the display off
                cfg_next.disp_en = wr_byte_in[`LSD_MODE_S]
                    && wr_byte_in[`LSD_MODE_E];
                // a one in the bias bit selects half bias
                cfg_next.bias_select = wr_byte_in[`LSD_MODE_BIAS];
            end else if (is_blink) begin
                cfg_next.blink_rate_code = wr_byte_in[1:0];
            end else if (is_lvl) begin
                cfg_next.level_adjust_en = wr_byte_in[`LSD_LVL_DE];
                cfg_next.supply_detect_en = wr_byte_in[`LSD_LVL_VE];
                cfg_next.drive_level_code = wr_byte_in[3:0];
            end
        end
    end

    // configuration, pointer and stream state
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_reg.frame_fast <= 1'b0;
            cfg_reg.osc_en <= 1'b0;
            cfg_reg.disp_en <= 1'b0;
            cfg_reg.bias_select <= 1'b0;
            cfg_reg.blink_rate_code <= `LSD_RST_BLINK;
            cfg_reg.drive_level_code <= `LSD_RST_LEVEL_CODE;
            cfg_reg.level_adjust_en <= 1'b1;
            cfg_reg.supply_detect_en <= 1'b0;
            ptr_reg <= `LSD_RST_PTR;
            wr_state_reg <= lsd_pkg::LSD_WR_IDLE;
        end else begin
            cfg_reg <= cfg_next;
            ptr_reg <= ptr_next;
            wr_state_reg <= wr_state_next;
        end
    end

    // ram write and read-back; ram has no reset, content is undefined
    // at power-up so software must load it before enabling the display
    always_ff @(posedge clk_sys_in) begin
        if (data_take) begin
            // bit 7 first on the wire lands in bit 7 here
            ram_reg[ptr_reg] <= wr_byte_in;
        end
    end

    // read-back follows the next pointer, so an acked byte is
    // replaced by the following word one cycle after the ack
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_byte_reg <= 8'h00;
        end else begin
            rd_byte_reg <= ram_reg[ptr_next];
        end
    end

    // latch copies ram at each frame start so a frame never tears;
    // while dark it tracks ram so enabling shows fresh data
    always_ff @(posedge clk_sys_in) begin
        if (tick.frame_start || !disp_live) begin
            latch_reg <= ram_reg;
        end
    end

    // time base: oscillator emulation, multiplex phase, blink count
    // everything on the panel side steps from its strobes
    lsd_timebase u_timebase (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .osc_en_in(cfg_reg.osc_en),
        .frame_fast_in(cfg_reg.frame_fast),
        .blink_rate_code_in(cfg_reg.blink_rate_code),
        .tick_out(tick)
    );

    // per-electrode waveform
    genvar e;
    generate
        for (e = 0; e < `LSD_NUM_ELEC; e++) begin : g_elec
            // word e/2; even electrode low nibble, odd high
            wire [3:0] nib = latch_reg[e / 2][(e % 2) * 4 +: 4];
            // nibble bit n belongs to backplane n
            wire seg_on = nib[tick.phase] && !tick.blink_off;
            assign elec_next[e] = disp_live
                ? seg_level(seg_on, tick.invert, cfg_reg.bias_select)
                : lsd_pkg::LSD_LVL_VDD;
        end
    endgenerate

    // per-backplane waveform
    genvar b;
    generate
        for (b = 0; b < `LSD_NUM_BP; b++) begin : g_bp
            wire sel = tick.phase == 2'(b);
            assign bp_next[b] = disp_live
                ? bp_level(sel, tick.invert, cfg_reg.bias_select)
                : lsd_pkg::LSD_LVL_VDD;
        end
    endgenerate

    // registered drive levels
    // a cycle of latency keeps the pins free of decode glitches
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            elec_reg <= {`LSD_NUM_ELEC{lsd_pkg::LSD_LVL_VDD}};
            bp_reg <= {`LSD_NUM_BP{lsd_pkg::LSD_LVL_VDD}};
        end else begin
            elec_reg <= elec_next;
            bp_reg <= bp_next;
        end
    end

    // outputs
    assign rd_byte_out = rd_byte_reg;
    assign pointer_out = ptr_reg;
    // configuration leaves as one struct for status read-out
    assign cfg_out = cfg_reg;
    // bias generator runs with the oscillator
    assign bias_gen_on_out = cfg_reg.osc_en;
    // centre element out for half bias
    assign divider_center_bypass_out = cfg_reg.bias_select;
    assign panel_electrode_drive_out = elec_reg;
    assign backplane_drive_out = bp_reg;

    // checks
    // each property samples on the system clock and idles in reset
    dark_high_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        !disp_live |=> (elec_reg == {`LSD_NUM_ELEC{lsd_pkg::LSD_LVL_VDD}})
            && (bp_reg == {`LSD_NUM_BP{lsd_pkg::LSD_LVL_VDD}}))
        else $error("outputs not at supply while dark");
    ptr_wrap_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        data_take && ptr_reg == `LSD_PTR_LAST |=> ptr_reg == 5'h00)
        else $error("pointer did not wrap to zero");
    ptr_step_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        ptr_step && !cmd_take && ptr_reg < `LSD_PTR_LAST
            |=> ptr_reg == $past(ptr_reg) + 5'h01)
        else $error("pointer did not step by one");
    ram_store_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        data_take |=> ram_reg[$past(ptr_reg)] == $past(wr_byte_in))
        else $error("data byte not stored");
    mode_set_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        cmd_take && is_mode && !is_ptr
            |=> cfg_reg.bias_select == $past(wr_byte_in[0])
            && divider_center_bypass_out == $past(wr_byte_in[0]))
        else $error("mode set not applied");
    osc_gate_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        !cfg_reg.osc_en |-> !cfg_reg.disp_en && !bias_gen_on_out)
        else $error("display on without oscillator");
    blink_set_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        cmd_take && is_blink
            |=> cfg_reg.blink_rate_code == $past(wr_byte_in[1:0]))
        else $error("blink code not applied");
    blank_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        disp_live && tick.blink_off |=> elec_reg == {`LSD_NUM_ELEC{
            seg_level(1'b0, $past(tick.invert), $past(cfg_reg.bias_select))}})
        else $error("electrodes not blanked in blink off half");
    skip_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        cmd_take && !is_ptr |=> wr_state_reg == lsd_pkg::LSD_WR_SKIP)
        else $error("bytes after a command not ignored");
    // pointer command opens a data run at the given word
    ptr_load_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        cmd_take && is_ptr |=> ptr_reg == $past(wr_byte_in[4:0])
            && wr_state_reg == lsd_pkg::LSD_WR_DATA)
        else $error("pointer command not loaded");
    // data with no pointer command must leave the pointer alone
    data_drop_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        wr_valid_in && !wr_first_in && !rd_ack_in
            && wr_state_reg != lsd_pkg::LSD_WR_DATA |=> $stable(ptr_reg))
        else $error("data byte taken without a pointer command");
    // after an ack the read byte already shows the new word
    rd_follow_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        rd_ack_in && !wr_valid_in |=> rd_byte_reg == ram_reg[ptr_reg])
        else $error("read byte does not follow pointer");
    // command fields land one cycle after the byte
    lvl_set_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        cmd_take && is_lvl
            |=> cfg_reg.drive_level_code == $past(wr_byte_in[3:0]))
        else $error("drive level code not applied");
    frame_set_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        cmd_take && is_mode
            |=> cfg_reg.frame_fast == $past(wr_byte_in[`LSD_MODE_F])
            && cfg_reg.osc_en == $past(wr_byte_in[`LSD_MODE_S]))
        else $error("frame rate or oscillator bit not applied");
    // selected backplane sits on a rail whose side follows the frame
    bp_select_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        disp_live |=> bp_reg[$past(tick.phase)]
            == flip_level(lsd_pkg::LSD_LVL_VDD, $past(tick.invert)))
        else $error("selected backplane not on its rail");
    // top word, odd electrode: bits 7..4 by backplane
    seg_map_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        disp_live && !tick.blink_off |=> elec_reg[43] == seg_level(
            $past(latch_reg[`LSD_RAM_WORDS - 1][4 + tick.phase]),
            $past(tick.invert), $past(cfg_reg.bias_select)))
        else $error("top electrode not taken from high nibble");
endmodule

/* File: core/lsd_timebase.sv */
// oscillator emulation, multiplex phase and blink timing
`timescale 1ns/10ps
`include "lsd_map.svh"
module lsd_timebase (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic osc_en_in,
    input wire logic frame_fast_in,
    input wire logic [1:0] blink_rate_code_in,
    output lsd_pkg::lsd_tick_s tick_out
);
    localparam logic [11:0] DIV_LAST = 12'(`LSD_OSC_DIV - 1);
    localparam logic [6:0] SLOW_LAST = 7'(`LSD_PHASE_SLOW - 1);
    localparam logic [6:0] FAST_LAST = 7'(`LSD_PHASE_FAST - 1);
    logic [11:0] div_reg;   // system clocks within one oscillator tick
    logic [6:0] slot_reg;   // oscillator ticks within one phase
    logic [1:0] phase_reg;  // active backplane
    logic inv_reg;          // frame polarity, flips every frame
    logic [15:0] blink_reg; // free count of oscillator ticks
    wire osc_tick = osc_en_in && (div_reg == DIV_LAST);
    // phase length follows the frame-rate bit
    wire [6:0] slot_last = frame_fast_in ? FAST_LAST : SLOW_LAST;
    wire slot_wrap = osc_tick && (slot_reg == slot_last);
    wire frame_wrap = slot_wrap && (phase_reg == 2'(`LSD_PHASES - 1));
    // a stopped oscillator freezes every count
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_reg <= 12'h000;
            slot_reg <= 7'h00;
            phase_reg <= 2'h0;
            inv_reg <= 1'b0;
            blink_reg <= 16'h0000;
        end else if (osc_en_in) begin
            div_reg <= osc_tick ? 12'h000 : div_reg + 12'h001;
            if (osc_tick) begin
                slot_reg <= slot_wrap ? 7'h00 : slot_reg + 7'h01;
                blink_reg <= blink_reg + 16'h0001;
            end
            if (slot_wrap) begin
                phase_reg <= phase_reg + 2'h1;
            end
            if (frame_wrap) begin
                inv_reg <= !inv_reg;
            end
        end
    end
    // off half of the blink period by mode
    logic blink_off;
    always_comb begin
        unique case (blink_rate_code_in)
            2'h0: blink_off = 1'b0;
            2'h1: blink_off = blink_reg[`LSD_BLINK_BIT_2HZ];
            2'h2: blink_off = blink_reg[`LSD_BLINK_BIT_1HZ];
            2'h3: blink_off = blink_reg[`LSD_BLINK_BIT_HALF];
        endcase
    end
    assign tick_out.phase = phase_reg;
    assign tick_out.invert = inv_reg;
    assign tick_out.frame_start = frame_wrap;
    assign tick_out.blink_off = blink_off;

    osc_stop_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        !osc_en_in |=> $stable(phase_reg) && $stable(blink_reg))
        else $error("phase moved while oscillator stopped");
    phase_step_a: assert property (@(posedge clk_sys_in)
        disable iff (!resetn_in)
        slot_wrap |=> phase_reg == $past(phase_reg) + 2'h1)
        else $error("backplane phase did not advance");
endmodule

/* File: testbench/lsd_host_model.sv */
// host-side byte source standing in for the two-wire bus master
`timescale 1ns/10ps
module lsd_host_model #(
    parameter int POWERUP_WAIT = 8 // settle time after reset, shortened
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    output logic wr_valid_out,
    output logic wr_first_out,
    output logic [7:0] wr_byte_out,
    output logic rd_ack_out
);
    logic [7:0] settle_reg; // counts down the settle time after reset

    // bus starts released: no byte offered, data lines parked
    initial begin
        wr_valid_out = 1'b0;
        wr_first_out = 1'b0;
        wr_byte_out = 8'h00;
        rd_ack_out = 1'b0;
    end

    // no byte is sent until the internal reset has had time to finish; read acks do not wait
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            settle_reg <= 8'(POWERUP_WAIT);
        end else if (settle_reg != 8'h00) begin
            settle_reg <= settle_reg - 8'h01;
        end
    end

    // one byte at its ack clock; first marks a command byte
    task automatic send_byte(input logic first, input logic [7:0] b);
        logic [7:0] shift;
        int i;
        shift = 8'h00;
        while (settle_reg != 8'h00) @(posedge clk_sys_in);
        // bits leave most significant first, so the shifter rebuilds b
        for (i = 7; i >= 0; i--) begin
            shift = {shift[6:0], b[i]};
        end
        @(posedge clk_sys_in);
        wr_valid_out <= 1'b1;
        wr_first_out <= first;
        wr_byte_out <= shift;
        @(posedge clk_sys_in);
        wr_valid_out <= 1'b0;
        wr_first_out <= 1'b0;
        // released data shows the inverse so stale values never match
        wr_byte_out <= ~shift;
    endtask

    // acknowledge of one byte read back by the host
    task automatic read_ack();
        @(posedge clk_sys_in);
        rd_ack_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_ack_out <= 1'b0;
    endtask
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the segment lcd driver core
`timescale 1ns/10ps
module tb;
    logic clk_sys_in;
    logic resetn_in;
    logic wr_valid, wr_first, rd_ack;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic [4:0] pointer;
    lsd_pkg::lsd_cfg_s cfg;
    logic bias_gen_on, bypass;
    lsd_pkg::lsd_level_e [43:0] elec;
    lsd_pkg::lsd_level_e [3:0] bp;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] mode_b [5] = '{8'h9d, 8'h88, 8'h84, 8'h81, 8'h8c};
    logic [3:0] mode_x [5] = '{4'hf, 4'h4, 4'h0, 4'h1, 4'h6};

    // 100 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    lsd_host_model lsd_host_model_inst (.clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in), .wr_valid_out(wr_valid),
        .wr_first_out(wr_first), .wr_byte_out(wr_byte),
        .rd_ack_out(rd_ack));

    lsd_core lsd_core_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .wr_valid_in(wr_valid), .wr_first_in(wr_first),
        .wr_byte_in(wr_byte), .rd_ack_in(rd_ack), .rd_byte_out(rd_byte),
        .pointer_out(pointer), .cfg_out(cfg), .bias_gen_on_out(bias_gen_on),
        .divider_center_bypass_out(bypass),
        .panel_electrode_drive_out(elec), .backplane_drive_out(bp));

    // compare one value and count it
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // distinct display pattern per ram address
    function automatic logic [7:0] pat(input int a);
        return 8'(a * 37 + 11);
    endfunction

    // let registered outputs land before looking
    task automatic settle();
        @(negedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask

    // a hang is cut short well beyond the longest expected run
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            stop_test();
        end
    end

    initial begin
        int e, k, sel;
        logic inv, bit_on;
        logic [7:0] word;
        lsd_pkg::lsd_level_e exp_l;
        resetn_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        settle();
        // power-on state
        chk(16'(cfg), 16'h0002);
        chk({bias_gen_on, bypass}, 16'h0000);
        chk(16'(pointer), 16'h0000);
        for (e = 0; e < 44; e++) chk(16'(elec[e]), 16'h0003);
        for (e = 0; e < 4; e++) chk(16'(bp[e]), 16'h0003);
        // fill all 22 words in one run; pointer wraps past 15h
        lsd_host_model_inst.send_byte(1'b1, 8'h00);
        for (k = 0; k < 22; k++) lsd_host_model_inst.send_byte(1'b0, pat(k));
        settle();
        chk(16'(pointer), 16'h0000);
        // read back from 05h, then step with acks
        lsd_host_model_inst.send_byte(1'b1, 8'h05);
        settle();
        chk(16'(rd_byte), 16'(pat(5)));
        lsd_host_model_inst.read_ack();
        settle();
        chk({3'h0, pointer, rd_byte}, {3'h0, 5'h06, pat(6)});
        lsd_host_model_inst.send_byte(1'b1, 8'h15);
        lsd_host_model_inst.read_ack();
        settle();
        chk({3'h0, pointer, rd_byte}, {8'h00, pat(0)});
        // pointer beyond the last word is ignored with its data
        lsd_host_model_inst.send_byte(1'b1, 8'h16);
        lsd_host_model_inst.send_byte(1'b0, 8'hff);
        settle();
        chk({3'h0, pointer, rd_byte}, {8'h00, pat(0)});
        // undefined command leaves configuration alone
        lsd_host_model_inst.send_byte(1'b1, 8'he0);
        settle();
        chk(16'(cfg), 16'h0002);
        // every blink code
        for (k = 3; k >= 0; k--) begin
            lsd_host_model_inst.send_byte(1'b1, 8'hc0 | 8'(k));
            settle();
            chk(16'(cfg.blink_rate_code), 16'(k));
        end
        // drive level extremes
        lsd_host_model_inst.send_byte(1'b1, 8'h4f);
        settle();
        chk(16'(cfg[5:0]), 16'h003c);
        lsd_host_model_inst.send_byte(1'b1, 8'h70);
        settle();
        chk(16'(cfg[5:0]), 16'h0003);
        // mode table: fast, osc, display, bias; last leaves display on
        for (k = 0; k < 5; k++) begin
            lsd_host_model_inst.send_byte(1'b1, mode_b[k]);
            settle();
            chk(16'(cfg[11:8]), 16'(mode_x[k]));
            chk({bias_gen_on, bypass},
                {mode_x[k][2], mode_x[k][0]});
        end
        // past one oscillator tick, then judge the panel levels
        repeat (3100) @(negedge clk_sys_in);
        sel = 0;
        for (k = 0; k < 4; k++) begin
            if (bp[k] === lsd_pkg::LSD_LVL_VDD
                || bp[k] === lsd_pkg::LSD_LVL_VSS)
                sel = k;
        end
        inv = (bp[sel] === lsd_pkg::LSD_LVL_VSS);
        for (k = 0; k < 4; k++) begin
            exp_l = (k == sel) ? (inv ? lsd_pkg::LSD_LVL_VSS
                : lsd_pkg::LSD_LVL_VDD) : (inv ? lsd_pkg::LSD_LVL_HIGH
                : lsd_pkg::LSD_LVL_LOW);
            chk(16'(bp[k]), 16'(exp_l));
        end
        for (e = 0; e < 44; e++) begin
            word = pat(e / 2);
            bit_on = word[(e % 2) * 4 + sel];
            exp_l = bit_on ? (inv ? lsd_pkg::LSD_LVL_VDD
                : lsd_pkg::LSD_LVL_VSS) : (inv ? lsd_pkg::LSD_LVL_LOW
                : lsd_pkg::LSD_LVL_HIGH);
            chk(16'(elec[e]), 16'(exp_l));
        end
        stop_test();
    end
endmodule
